/* verilog/vr_param_checker.sv */
`timescale 1ns/1ps
module vr_param_checker (
	input  wire logic                    CLK_SYS,
	input  wire logic                    RST_N,
	input  wire logic                    PS_VALID,
	input  wire logic                    PS_IS_VPS,
	input  wire logic [6:0]              PROFILE_IDC,
	input  wire logic                    TIER_FLAG,
	input  wire logic [7:0]              LEVEL_IDC,
	input  wire logic [2:0]              LUMA_DEPTH_M8,
	input  wire logic [2:0]              CHROMA_DEPTH_M8,
	input  wire logic [15:0]             PIC_WIDTH,
	input  wire logic [15:0]             PIC_HEIGHT,
	input  wire logic                    VUI_PRESENT,
	input  wire logic                    SIGNAL_TYPE_PRESENT,
	input  wire logic                    COLOUR_DESC_PRESENT,
	input  wire logic [7:0]              PRIMARIES,
	input  wire logic [7:0]              TRANSFER,
	input  wire logic [7:0]              MATRIX,
	input  wire logic                    TIMING_PRESENT,
	input  wire logic [31:0]             UNITS_IN_TICK,
	input  wire logic [31:0]             TIME_SCALE,
	input  wire logic                    FIXED_RATE_PRESENT,
	input  wire logic                    FIXED_RATE_FLAG,
	input  wire logic [1:0]              CHROMA_FORMAT,
	input  wire logic                    PROGRESSIVE_SRC,
	input  wire logic                    INTERLACED_SRC,
	input  wire logic                    FRAME_ONLY,
	input  wire logic                    ASPECT_PRESENT,
	input  wire logic [7:0]              ASPECT_IDC,
	input  wire logic                    RAP_VALID,
	input  wire logic [32:0]             RAP_DTS,
	input  wire logic [13:0]             ERR_CLR,
	output logic [13:0]                  ERR,
	output vr_chk_pkg::colour_cfg_t      COLOUR_CFG,
	output logic                         DEPTH_10BIT,
	output logic                         PS_ACCEPT
);
	import vr_chk_pkg::*;

	rate_if rif ();

	logic              ps_take;
	logic [ERR_W-1:0]  err_set;
	logic [ERR_W-1:0]  err_d;
	logic [ERR_W-1:0]  err_q;
	colour_cfg_t       cfg_d;
	colour_cfg_t       cfg_q;
	logic              depth10_d;
	logic              depth10_q;
	logic              accept_d;
	logic              accept_q;
	logic [31:0]       ref_units_d;
	logic [31:0]       ref_units_q;
	logic [31:0]       ref_scale_d;
	logic [31:0]       ref_scale_q;
	logic              ref_valid_d;
	logic              ref_valid_q;
	logic [32:0]       rap_prev_d;
	logic [32:0]       rap_prev_q;
	logic              rap_seen_d;
	logic              rap_seen_q;
	logic [32:0]       rap_gap;

	// parameter sets of the video kind never reach the checks
	assign ps_take = PS_VALID && !PS_IS_VPS;

	// rate compare only when timing is coded
	assign rif.valid = ps_take && TIMING_PRESENT;
	assign rif.units = UNITS_IN_TICK;
	assign rif.scale = TIME_SCALE;

	frame_rate_match u_rate (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.rif   (rif)
	);

	assign rap_gap = RAP_DTS - rap_prev_q;

	always_comb begin
		err_set = '0;
		cfg_d   = cfg_q;
		if (ps_take) begin
			err_set[E_PROFILE]  = PROFILE_IDC != PROFILE_MAIN10;
			err_set[E_TIER]     = TIER_FLAG != TIER_MAIN;
			err_set[E_LEVEL]    = LEVEL_IDC > LEVEL_MAX;
			err_set[E_DEPTH]    = ((LUMA_DEPTH_M8 != DEPTH_M8_8BIT) && (LUMA_DEPTH_M8 != DEPTH_M8_10BIT))
				|| (CHROMA_DEPTH_M8 != LUMA_DEPTH_M8);
			err_set[E_SIZE]     = (PIC_WIDTH > LUMA_DIM_MAX) || (PIC_HEIGHT > LUMA_DIM_MAX);
			err_set[E_VUI]      = !VUI_PRESENT;
			err_set[E_COLOUR_PR] = !(VUI_PRESENT && SIGNAL_TYPE_PRESENT && COLOUR_DESC_PRESENT);
			if (PRIMARIES == CP_BT709 && TRANSFER == TC_BT709 && MATRIX == MC_BT709) begin
				cfg_d = CFG_BT709;
			end else if (PRIMARIES == CP_BT2020 && TRANSFER == TC_BT2020_SDR && MATRIX == MC_BT2020) begin
				cfg_d = CFG_2020_SDR;
			end else if (PRIMARIES == CP_BT2020 && TRANSFER == TC_PQ && MATRIX == MC_BT2020) begin
				cfg_d = CFG_2020_PQ;
			end else begin
				cfg_d = CFG_NONE;
			end
			err_set[E_COLOUR_CFG] = (cfg_d == CFG_NONE) && !err_set[E_COLOUR_PR];
			// fixed rate flag and rate held since last access point
			err_set[E_FIXED_RATE] = (TIMING_PRESENT && FIXED_RATE_PRESENT && !FIXED_RATE_FLAG)
				|| (TIMING_PRESENT && ref_valid_q && (UNITS_IN_TICK != ref_units_q || TIME_SCALE != ref_scale_q));
			err_set[E_CHROMA]   = CHROMA_FORMAT != CHROMA_420;
			err_set[E_PROGRESS] = !PROGRESSIVE_SRC || INTERLACED_SRC || !FRAME_ONLY;
			err_set[E_ASPECT]   = !(VUI_PRESENT && ASPECT_PRESENT && ASPECT_IDC == ASPECT_SQUARE);
		end
		err_set[E_RATE] = rif.done && !rif.ok;
		err_set[E_RAP_GAP] = RAP_VALID && rap_seen_q && (rap_gap > RAP_MAX_TICKS);
		err_d = (err_q & ~ERR_CLR) | err_set;
	end

	// no reference decoder inputs; timing only checked, never enforced
	always_comb begin
		depth10_d   = ps_take ? (LUMA_DEPTH_M8 == DEPTH_M8_10BIT) : depth10_q;
		accept_d    = ps_take;
		rap_seen_d  = rap_seen_q || RAP_VALID;
		rap_prev_d  = RAP_VALID ? RAP_DTS : rap_prev_q;
		ref_valid_d = ref_valid_q;
		ref_units_d = ref_units_q;
		ref_scale_d = ref_scale_q;
		// Reference rate restarts at each access point
		if (RAP_VALID) begin
			ref_valid_d = 1'b0;
		end else if (rif.valid && !ref_valid_q) begin
			ref_valid_d = 1'b1;
			ref_units_d = UNITS_IN_TICK;
			ref_scale_d = TIME_SCALE;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			err_q       <= '0;
			cfg_q       <= CFG_NONE;
			depth10_q   <= 1'b0;
			accept_q    <= 1'b0;
			ref_valid_q <= 1'b0;
			ref_units_q <= 32'h0;
			ref_scale_q <= 32'h0;
			rap_seen_q  <= 1'b0;
			rap_prev_q  <= 33'h0;
		end else begin
			err_q       <= err_d;
			cfg_q       <= cfg_d;
			depth10_q   <= depth10_d;
			accept_q    <= accept_d;
			ref_valid_q <= ref_valid_d;
			ref_units_q <= ref_units_d;
			ref_scale_q <= ref_scale_d;
			rap_seen_q  <= rap_seen_d;
			rap_prev_q  <= rap_prev_d;
		end
	end

	assign ERR         = err_q;
	assign COLOUR_CFG  = cfg_q;
	assign DEPTH_10BIT = depth10_q;
	assign PS_ACCEPT   = accept_q;

	sequence s_bad_rate;
		ps_take && TIMING_PRESENT && UNITS_IN_TICK == 32'h1 && TIME_SCALE == 32'h1D;
	endsequence
	sequence s_rate_flagged;
		##2 err_q[E_RATE];
	endsequence

	a_err_sticky: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		err_q[E_LEVEL] && !ERR_CLR[E_LEVEL] |=> err_q[E_LEVEL])
		else $error("Error flag dropped without clear");
	a_profile_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		ps_take && PROFILE_IDC != 7'h02 |=> err_q[E_PROFILE])
		else $error("Wrong profile not flagged");
	a_level_limit: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		ps_take && LEVEL_IDC == 8'h99 && err_q[E_LEVEL] == 1'b0 |=> !err_q[E_LEVEL])
		else $error("Level 153 wrongly flagged");
	a_depth_10: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		ps_take && LUMA_DEPTH_M8 == 3'h2 && CHROMA_DEPTH_M8 == 3'h2
		|=> DEPTH_10BIT && (!err_q[E_DEPTH] || $past(err_q[E_DEPTH])))
		else $error("10-bit stream not accepted");
	a_size_limit: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		ps_take && PIC_WIDTH == 16'h2001 |=> err_q[E_SIZE])
		else $error("Oversize width not flagged");
	a_pq_config: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		ps_take && PRIMARIES == 8'h09 && TRANSFER == 8'h10 && MATRIX == 8'h09 |=> COLOUR_CFG == CFG_2020_PQ)
		else $error("PQ configuration not recognised");
	a_rate_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		s_bad_rate |-> s_rate_flagged)
		else $error("Bad frame rate not flagged");
	a_rap_gap: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		RAP_VALID && rap_seen_q && (RAP_DTS - rap_prev_q) == 33'd450001 |=> err_q[E_RAP_GAP])
		else $error("Long access point gap not flagged");
	a_vps_ignored: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		PS_VALID && PS_IS_VPS && !RAP_VALID && !rif.done |=> !PS_ACCEPT && $stable(COLOUR_CFG))
		else $error("Video parameter set not ignored");
	a_progressive: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		ps_take && INTERLACED_SRC |=> err_q[E_PROGRESS])
		else $error("Interlaced source not flagged");
endmodule : vr_param_checker

/* verilog/vr_chk_pkg.sv */
package vr_chk_pkg;

	// Error flag positions, one sticky flag per checked parameter
	localparam int ERR_W        = 14;
	localparam int E_PROFILE    = 0;
	localparam int E_TIER       = 1;
	localparam int E_LEVEL      = 2;
	localparam int E_DEPTH      = 3;
	localparam int E_SIZE       = 4;
	localparam int E_COLOUR_PR  = 5;
	localparam int E_COLOUR_CFG = 6;
	localparam int E_RATE       = 7;
	localparam int E_FIXED_RATE = 8;
	localparam int E_RAP_GAP    = 9;
	localparam int E_VUI        = 10;
	localparam int E_CHROMA     = 11;
	localparam int E_PROGRESS   = 12;
	localparam int E_ASPECT     = 13;

	localparam logic [6:0]  PROFILE_MAIN10   = 7'h02;
	localparam logic        TIER_MAIN        = 1'h0;
	localparam logic [7:0]  LEVEL_MAX        = 8'h99;
	localparam logic [2:0]  DEPTH_M8_8BIT    = 3'h0;
	localparam logic [2:0]  DEPTH_M8_10BIT   = 3'h2;
	localparam logic [15:0] LUMA_DIM_MAX     = 16'h2000;
	localparam logic [7:0]  CP_BT709         = 8'h01;
	localparam logic [7:0]  CP_BT2020        = 8'h09;
	localparam logic [7:0]  TC_BT709         = 8'h01;
	localparam logic [7:0]  TC_BT2020_SDR    = 8'h0E;
	localparam logic [7:0]  TC_PQ            = 8'h10;
	localparam logic [7:0]  MC_BT709         = 8'h01;
	localparam logic [7:0]  MC_BT2020        = 8'h09;
	localparam logic [1:0]  CHROMA_420       = 2'h1;
	localparam logic [7:0]  ASPECT_SQUARE    = 8'h01;

	// Frame rates as time_scale / units_in_tick = RATE_NUM / RATE_DEN
	localparam int          RATE_CNT = 11;
	localparam int          RATE_NUM [RATE_CNT] = '{24, 25, 30, 24000, 30000, 50, 60, 60000, 90, 100, 120};
	localparam int          RATE_DEN [RATE_CNT] = '{1, 1, 1, 1001, 1001, 1, 1, 1001, 1, 1, 1};

	// Decode time stamps count at 90 kHz
	localparam int          DTS_HZ        = 90000;
	localparam int          RAP_MAX_S     = 5;
	localparam logic [32:0] RAP_MAX_TICKS = 33'(RAP_MAX_S * DTS_HZ);

	typedef enum logic [1:0] {
		CFG_NONE     = 2'b00,
		CFG_BT709    = 2'b01,
		CFG_2020_SDR = 2'b10,
		CFG_2020_PQ  = 2'b11
	} colour_cfg_t;

endpackage : vr_chk_pkg

/* verilog/rate_if.sv */
`timescale 1ns/1ps
interface rate_if;
	logic        valid;
	logic [31:0] units;
	logic [31:0] scale;
	logic        done;
	logic        ok;

	modport requester (output valid, output units, output scale, input done, input ok);
	modport matcher   (input valid, input units, input scale, output done, output ok);
endinterface : rate_if

/* verilog/frame_rate_match.sv */
`timescale 1ns/1ps
module frame_rate_match
	import vr_chk_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	rate_if.matcher  rif
);
	logic [RATE_CNT-1:0] hit;
	logic                done_d;
	logic                done_q;
	logic                ok_d;
	logic                ok_q;

	// One exact cross-multiplied compare per permitted rate
	genvar g;
	generate
		for (g = 0; g < RATE_CNT; g++) begin : g_rate
			assign hit[g] = (64'(rif.scale) * 64'(RATE_DEN[g])) == (64'(rif.units) * 64'(RATE_NUM[g]));
		end
	endgenerate

	always_comb begin
		done_d = rif.valid;
		ok_d   = rif.valid ? ((rif.units != 32'h0) && (|hit)) : ok_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			ok_q   <= 1'b0;
		end else begin
			done_q <= done_d;
			ok_q   <= ok_d;
		end
	end

	assign rif.done = done_q;
	assign rif.ok   = ok_q;

	a_rate_120hz: assert property (@(posedge clk) disable iff (!rst_n)
		rif.valid && rif.units == 32'h1 && rif.scale == 32'h78 |=> rif.done && rif.ok)
		else $error("120 Hz timing not accepted");
	a_rate_zero_tick: assert property (@(posedge clk) disable iff (!rst_n)
		rif.valid && rif.units == 32'h0 |=> !rif.ok)
		else $error("Zero tick count accepted");
endmodule : frame_rate_match

/* dv/ps_source.sv */
`timescale 1ns/1ps
module ps_source
	import vr_chk_pkg::*;
(
	input  wire logic   clk,
	output logic        ps_valid,
	output logic        ps_is_vps,
	output logic [6:0]  profile_idc,
	output logic        tier_flag,
	output logic [7:0]  level_idc,
	output logic [2:0]  luma_m8,
	output logic [2:0]  chroma_m8,
	output logic [15:0] width,
	output logic [15:0] height,
	output logic        vui_on,
	output logic        sig_type_on,
	output logic        colour_on,
	output logic [7:0]  prim,
	output logic [7:0]  xfer,
	output logic [7:0]  matrix,
	output logic        timing_on,
	output logic [31:0] units,
	output logic [31:0] scale,
	output logic        fixed_on,
	output logic        fixed_flag,
	output logic [1:0]  chroma_fmt,
	output logic        prog_src,
	output logic        intl_src,
	output logic        frame_only,
	output logic        aspect_on,
	output logic [7:0]  aspect_idc,
	output logic        rap_valid,
	output logic [32:0] rap_dts
);
	initial begin
		{ps_valid, ps_is_vps, profile_idc, tier_flag, level_idc, luma_m8, chroma_m8, width, height, vui_on} = '0;
		{sig_type_on, colour_on, prim, xfer, matrix, timing_on, units, scale, fixed_on, fixed_flag} = '0;
		{chroma_fmt, prog_src, intl_src, frame_only, aspect_on, aspect_idc, rap_valid, rap_dts} = '0;
	end

	// Fault -1 sends a clean set; a flag index other than E_RATE or E_RAP_GAP breaks that one field
	task automatic send(input int fault, input logic [1:0] cfg, input logic ten, input logic vps,
		input logic [31:0] u, input logic [31:0] s);
		@(posedge clk);
		ps_valid <= 1'h1;
		ps_is_vps <= vps;
		profile_idc <= (fault == E_PROFILE) ? 7'h03 : PROFILE_MAIN10;
		tier_flag <= (fault == E_TIER) ? 1'h1 : TIER_MAIN;
		level_idc <= (fault == E_LEVEL) ? 8'h9A : LEVEL_MAX;
		luma_m8 <= ten ? 3'h2 : 3'h0;
		chroma_m8 <= (fault == E_DEPTH) ? 3'h1 : (ten ? 3'h2 : 3'h0);
		width <= (fault == E_SIZE) ? 16'h2001 : 16'h2000;
		height <= 16'h2000;
		vui_on <= (fault != E_VUI);
		sig_type_on <= 1'h1;
		colour_on <= (fault != E_COLOUR_PR);
		prim <= (cfg == 2'h1) ? 8'h01 : 8'h09;
		xfer <= (fault == E_COLOUR_CFG) ? 8'h10 : (cfg == 2'h1) ? 8'h01 : (cfg == 2'h2) ? 8'h0E : 8'h10;
		matrix <= (cfg == 2'h1) ? 8'h01 : 8'h09;
		timing_on <= 1'h1;
		units <= u;
		scale <= s;
		fixed_on <= 1'h1;
		fixed_flag <= (fault != E_FIXED_RATE);
		chroma_fmt <= (fault == E_CHROMA) ? 2'h2 : CHROMA_420;
		prog_src <= 1'h1;
		intl_src <= (fault == E_PROGRESS);
		frame_only <= 1'h1;
		aspect_on <= 1'h1;
		aspect_idc <= (fault == E_ASPECT) ? 8'h02 : ASPECT_SQUARE;
		@(posedge clk);
		ps_valid <= 1'h0;
		// Released fields turn over so a stale value cannot pass
		{profile_idc, level_idc, prim, xfer, matrix, units, scale} <= ~{profile_idc, level_idc, prim, xfer, matrix, units, scale};
	endtask : send

	task automatic rap(input logic [32:0] dts);
		@(posedge clk);
		rap_valid <= 1'h1;
		rap_dts <= dts;
		@(posedge clk);
		rap_valid <= 1'h0;
		rap_dts <= ~dts;
	endtask : rap
endmodule : ps_source

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import vr_chk_pkg::*;
	logic        clk_sys, rst_n, ps_valid, ps_is_vps, tier_flag, vui_on, sig_type_on, colour_on, timing_on;
	logic        fixed_on, fixed_flag, prog_src, intl_src, frame_only, aspect_on, rap_valid, depth_10bit, ps_accept;
	logic [6:0]  profile_idc;
	logic [7:0]  level_idc, prim, xfer, matrix, aspect_idc;
	logic [2:0]  luma_m8, chroma_m8;
	logic [15:0] width, height;
	logic [31:0] units, scale;
	logic [1:0]  chroma_fmt;
	logic [32:0] rap_dts, dts;
	logic [13:0] err_clr, err;
	colour_cfg_t colour_cfg;
	int          errors, n_tests;
	int          nums [11] = '{24, 25, 30, 24000, 30000, 50, 60, 60000, 90, 100, 120};
	int          dens [11] = '{1, 1, 1, 1001, 1001, 1, 1, 1001, 1, 1, 1};

	ps_source src_u (.clk(clk_sys), .ps_valid, .ps_is_vps, .profile_idc, .tier_flag, .level_idc, .luma_m8,
		.chroma_m8, .width, .height, .vui_on, .sig_type_on, .colour_on, .prim, .xfer, .matrix, .timing_on,
		.units, .scale, .fixed_on, .fixed_flag, .chroma_fmt, .prog_src, .intl_src, .frame_only, .aspect_on,
		.aspect_idc, .rap_valid, .rap_dts);

	vr_param_checker dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .PS_VALID(ps_valid), .PS_IS_VPS(ps_is_vps),
		.PROFILE_IDC(profile_idc), .TIER_FLAG(tier_flag), .LEVEL_IDC(level_idc), .LUMA_DEPTH_M8(luma_m8),
		.CHROMA_DEPTH_M8(chroma_m8), .PIC_WIDTH(width), .PIC_HEIGHT(height), .VUI_PRESENT(vui_on),
		.SIGNAL_TYPE_PRESENT(sig_type_on), .COLOUR_DESC_PRESENT(colour_on), .PRIMARIES(prim), .TRANSFER(xfer),
		.MATRIX(matrix), .TIMING_PRESENT(timing_on), .UNITS_IN_TICK(units), .TIME_SCALE(scale),
		.FIXED_RATE_PRESENT(fixed_on), .FIXED_RATE_FLAG(fixed_flag), .CHROMA_FORMAT(chroma_fmt),
		.PROGRESSIVE_SRC(prog_src), .INTERLACED_SRC(intl_src), .FRAME_ONLY(frame_only), .ASPECT_PRESENT(aspect_on),
		.ASPECT_IDC(aspect_idc), .RAP_VALID(rap_valid), .RAP_DTS(rap_dts), .ERR_CLR(err_clr), .ERR(err),
		.COLOUR_CFG(colour_cfg), .DEPTH_10BIT(depth_10bit), .PS_ACCEPT(ps_accept));

	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop

	task automatic clear_all;
		@(posedge clk_sys);
		err_clr <= 14'h3FFF;
		@(posedge clk_sys);
		err_clr <= 14'h0000;
		#1;
		check(33'(err), 33'h0);
	endtask : clear_all

	// Access point one cycle on, then return 1 ns after the edge that samples it
	task automatic rap_next(input logic [32:0] gap);
		dts = dts + gap;
		src_u.rap(dts);
		#1;
	endtask : rap_next

	task automatic t_reset;
		check(33'({err, colour_cfg, depth_10bit, ps_accept}), 33'h0);
		dts = 33'h1ABCDEF01;
		rap_next(33'h0);
		check(33'(err), 33'h0);
	endtask : t_reset

	task automatic t_colour;
		for (int c = 1; c <= 3; c++) begin
			src_u.send(-1, 2'(c), c[0], 1'h0, 32'd1, 32'd30);
			#1;
			check(33'(ps_accept), 33'h1);
			check(33'(colour_cfg), 33'(c));
			check(33'(depth_10bit), 33'(c[0]));
			@(posedge clk_sys);
			#1;
			check(33'({ps_accept, err}), 33'h0);
		end
	endtask : t_colour

	task automatic t_faults;
		for (int k = 0; k < ERR_W; k++) begin
			if (k == E_RAP_GAP) continue;
			rap_next(33'd90000);
			src_u.send(k, (k == E_COLOUR_CFG) ? 2'h1 : 2'h2, 1'h1, 1'h0, 32'd1, (k == E_RATE) ? 32'd29 : 32'd30);
			#1;
			@(posedge clk_sys);
			#1;
			if (k == E_VUI) begin
				check(33'(err), 33'h2420);
			end else begin
				check(33'(err), 33'(14'h1 << k));
			end
			clear_all();
		end
	endtask : t_faults

	task automatic t_rate;
		for (int i = 0; i < 11; i++) begin
			rap_next(33'd90000);
			src_u.send(-1, 2'h3, 1'h0, 1'h0, 32'(dens[i] * 2), 32'(nums[i] * 2));
			repeat (2) @(posedge clk_sys);
			#1;
			check(33'(err), 33'h0);
		end
		src_u.send(-1, 2'h3, 1'h0, 1'h0, 32'd1, 32'd100);
		repeat (2) @(posedge clk_sys);
		#1;
		check(33'(err), 33'(14'h1 << E_FIXED_RATE));
		clear_all();
	endtask : t_rate

	task automatic t_gap;
		rap_next(33'd450000);
		check(33'(err), 33'h0);
		rap_next(33'd450001);
		check(33'(err), 33'(14'h1 << E_RAP_GAP));
		clear_all();
		dts = 33'h1FFFFFFF0;
		rap_next(33'h0);
		clear_all();
		rap_next(33'd450000);
		check(33'(err), 33'h0);
	endtask : t_gap

	task automatic t_vps;
		src_u.send(E_PROFILE, 2'h1, 1'h1, 1'h1, 32'd1, 32'd7);
		#1;
		check(33'({ps_accept, colour_cfg, depth_10bit}), 33'h6);
		repeat (2) @(posedge clk_sys);
		#1;
		check(33'(err), 33'h0);
	endtask : t_vps

	// Watchdog well past the two hundred or so cycles the sequence needs
	initial begin
		#100000;
		errors++;
		report_and_stop();
	end

	initial begin
		errors = 0;
		n_tests = 0;
		err_clr = 14'h0000;
		rst_n = 1'h0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'h1;
		#1;
		t_reset();
		t_colour();
		t_faults();
		t_rate();
		t_gap();
		t_vps();
		report_and_stop();
	end
endmodule : tb_top
